// ===== core/pmv_core.sv
// Notes on behaviour
// - code store holds 2048 words of 15 bits, addressed by pc.
// - reset loads pc with reset vector; execution starts there.
// - qualifying external edge jumps to its vector if enabled, stack not full.
// - external edge selectable: falling, rising or both.
// - each timer overflow jumps to own vector if enabled, stack not full.
// - conversion complete jumps to converter vector if enabled, not full.
// - time base overflow jumps to its vector if enabled, not full.
// - table pointer gives low eight bits of every table address.
// - current-page read uses pc upper bits; last-page read uses ones.
// - table read sends low byte to data memory, upper bits to high reg.
// - high register bits without code word bits read zero.
// - high register is read-only; only table reads change it.
// - every table instruction takes two cycles.
// - acknowledge pushes pc, call pushes pc plus one, onto stack before the jump.
// - full stack keeps flag set but withholds acknowledge until return.
`timescale 1ns/1ps
`default_nettype none
module pmv_core #(
  parameter int STACK_DEPTH = pmv_pkg::STACK_DEPTH
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, low active
  input wire pmv_pkg::pmv_axi_req_t axi_req, // register bus requests
  output var pmv_pkg::pmv_axi_rsp_t axi_rsp, // register bus answers
  input wire pmv_pkg::pmv_core_req_t core_req, // core control requests
  input wire logic ext_int_pin, // external interrupt pin
  input wire logic tmr0_ovf, // timer 0 overflow pulse
  input wire logic tmr1_ovf, // timer 1 overflow pulse
  input wire logic adc_done, // conversion complete pulse
  input wire logic tb_ovf, // time base overflow pulse
  output var logic [10:0] pc, // program counter
  output var logic [14:0] fetch_word, // word at pc
  output var logic busy, // table read second cycle
  output var logic int_ack, // interrupt taken this cycle
  output var logic tab_wr_en, // table low byte write strobe
  output var logic [6:0] tab_wr_addr, // data memory destination
  output var logic [7:0] tab_wr_data // table low byte
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

  logic ext_meta_q, ext_sync_q, ext_prev_q, ext_edge;
  logic [4:0] flags_q, flags_d, events, clr_mask, pending, ack_hot;
  logic [7:0] ctrl_q, ctrl_d, tblp_q, tblp_d, thb_q, thb_d;
  logic [10:0] pc_q, pc_d, tab_addr_q, tab_addr_d, prog_addr_q, prog_addr_d;
  logic [10:0] push_val, raddr, vec;
  logic [SP_W-1:0] sp_q, sp_d, push_idx;
  logic [10:0] stack_q [STACK_DEPTH];
  logic [10:0] stack_d [STACK_DEPTH];
  logic [6:0] tab_dest_q, tab_dest_d;
  pmv_pkg::pmv_tab_state_t tab_q, tab_d;
  logic stack_full, ack, push, tab_start, core_busy, mem_we;
  logic [14:0] mem_rdata;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d, wr_fire;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, wmask, rdata_q, rdata_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  function automatic logic known(input logic [7:0] a);
    known = a inside {pmv_pkg::OFF_TBLP, pmv_pkg::OFF_THB, pmv_pkg::OFF_CTRL,
      pmv_pkg::OFF_STATUS, pmv_pkg::OFF_PC, pmv_pkg::OFF_PROG_ADDR,
      pmv_pkg::OFF_PROG_DATA};
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      strb_mask[i*8 +: 8] = {8{s[i]}};
    end
  endfunction

  // the edge detector reads only the second and third stages
  always_ff @(posedge aclk) begin
    ext_meta_q <= ext_int_pin;
    ext_sync_q <= ext_meta_q;
    ext_prev_q <= ext_sync_q;
  end

  always_comb begin
    unique case (ctrl_q[pmv_pkg::CTL_EDGE_LSB +: 2])
      pmv_pkg::EDGE_FALL: ext_edge = ext_prev_q & ~ext_sync_q;
      pmv_pkg::EDGE_RISE: ext_edge = ~ext_prev_q & ext_sync_q;
      pmv_pkg::EDGE_BOTH: ext_edge = ext_prev_q ^ ext_sync_q;
      pmv_pkg::EDGE_OFF: ext_edge = 1'b0;
    endcase
  end

  assign events = {tb_ovf, adc_done, tmr1_ovf, tmr0_ovf, ext_edge};
  assign stack_full = (sp_q == SP_FULL);
  assign core_busy = (tab_q == pmv_pkg::TAB_DATA);
  assign pending = flags_q & ctrl_q[pmv_pkg::CTL_EN_LSB +: 5];
  assign tab_start = ~core_busy & (core_req.tab_cur | core_req.tab_last);
  // taken only at a plain step so no core jump is lost
  assign ack = ctrl_q[pmv_pkg::CTL_GIE] & (|pending) & ~stack_full
    & ~core_busy & core_req.step & ~core_req.jump & ~core_req.call
    & ~core_req.ret & ~tab_start;
  assign ack_hot = ack ? (pending & (~pending + 5'h1)) : 5'h0;

  always_comb begin
    unique case (1'b1)
      ack_hot[pmv_pkg::SRC_TMR0]: vec = pmv_pkg::VEC_TMR0;
      ack_hot[pmv_pkg::SRC_TMR1]: vec = pmv_pkg::VEC_TMR1;
      ack_hot[pmv_pkg::SRC_ADC]: vec = pmv_pkg::VEC_ADC;
      ack_hot[pmv_pkg::SRC_TB]: vec = pmv_pkg::VEC_TB;
      default: vec = pmv_pkg::VEC_EXT;
    endcase
  end

  // register bus write side
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign wmask = strb_mask(w_strb_q);
  assign clr_mask = (wr_fire && aw_addr_q == pmv_pkg::OFF_STATUS) ?
    (w_data_q[4:0] & wmask[4:0]) : 5'h0;
  assign mem_we = wr_fire && aw_addr_q == pmv_pkg::OFF_PROG_DATA
    && (&w_strb_q[1:0]);

  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (axi_req.awvalid && axi_rsp.awready) begin
      aw_held_d = 1'b1;
      aw_addr_d = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      w_held_d = 1'b1;
      w_data_d = axi_req.wdata;
      w_strb_d = axi_req.wstrb;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      // read-only and unknown locations refuse the write
      bresp_d = (known(aw_addr_q) && aw_addr_q != pmv_pkg::OFF_THB
        && aw_addr_q != pmv_pkg::OFF_PC) ?
        pmv_pkg::RESP_OKAY : pmv_pkg::RESP_SLVERR;
    end else if (bvalid_q && axi_req.bready) begin
      bvalid_d = 1'b0;
    end
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (axi_req.arvalid && axi_rsp.arready) begin
      rvalid_d = 1'b1;
      rresp_d = known(axi_req.araddr) ? pmv_pkg::RESP_OKAY
        : pmv_pkg::RESP_SLVERR;
      unique case (axi_req.araddr)
        pmv_pkg::OFF_TBLP: rdata_d = 32'(tblp_q);
        pmv_pkg::OFF_THB: rdata_d = 32'(thb_q);
        pmv_pkg::OFF_CTRL: rdata_d = 32'(ctrl_q);
        pmv_pkg::OFF_STATUS: rdata_d = 32'(flags_q)
          | (32'(sp_q) << pmv_pkg::ST_SP_LSB)
          | (32'(stack_full) << pmv_pkg::ST_FULL_BIT);
        pmv_pkg::OFF_PC: rdata_d = 32'(pc_q);
        pmv_pkg::OFF_PROG_ADDR: rdata_d = 32'(prog_addr_q);
        default: rdata_d = 32'h0000_0000;
      endcase
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_d = 1'b0;
    end
  end

  // flags, control, pointers, stack and table sequencer
  always_comb begin
    // set wins over a software clear or an acknowledge in the same cycle
    flags_d = (flags_q & ~clr_mask & ~ack_hot) | events;
    ctrl_d = ctrl_q;
    tblp_d = tblp_q;
    prog_addr_d = prog_addr_q;
    if (wr_fire && aw_addr_q == pmv_pkg::OFF_CTRL) begin
      ctrl_d = (ctrl_q & ~wmask[7:0]) | (w_data_q[7:0] & wmask[7:0]);
    end
    if (wr_fire && aw_addr_q == pmv_pkg::OFF_TBLP && w_strb_q[0]) begin
      tblp_d = w_data_q[7:0];
    end
    if (wr_fire && aw_addr_q == pmv_pkg::OFF_PROG_ADDR) begin
      prog_addr_d = w_data_q[10:0];
    end else if (mem_we) begin
      prog_addr_d = prog_addr_q + 11'h001;
    end
    pc_d = pc_q;
    sp_d = sp_q;
    stack_d = stack_q;
    push = 1'b0;
    push_val = pc_q;
    if (ack) begin
      push = 1'b1;
      pc_d = vec;
      ctrl_d[pmv_pkg::CTL_GIE] = 1'b0;
    end else if (!core_busy) begin
      if (core_req.ret) begin
        sp_d = (sp_q == '0) ? sp_q : sp_q - SP_W'(1);
        pc_d = stack_q[(sp_q == '0) ? '0 : sp_q - SP_W'(1)];
        if (core_req.reti) begin
          ctrl_d[pmv_pkg::CTL_GIE] = 1'b1;
        end
      end else if (core_req.call) begin
        push = 1'b1;
        push_val = pc_q + 11'h001;
        pc_d = core_req.jump_addr;
      end else if (core_req.jump) begin
        pc_d = core_req.jump_addr;
      end else if (core_req.step) begin
        pc_d = pc_q + 11'h001;
      end
    end
    // a call on a full stack overwrites the oldest level
    push_idx = stack_full ? '0 : sp_q;
    if (push) begin
      stack_d[push_idx] = push_val;
      sp_d = push_idx + SP_W'(1);
    end
    tab_d = tab_q;
    tab_addr_d = tab_addr_q;
    tab_dest_d = tab_dest_q;
    thb_d = thb_q;
    unique case (tab_q)
      pmv_pkg::TAB_IDLE: begin
        if (tab_start) begin
          tab_d = pmv_pkg::TAB_DATA;
          tab_addr_d = {core_req.tab_last ? pmv_pkg::LAST_PAGE
            : pc_q[10:8], tblp_q};
          tab_dest_d = core_req.tab_dest;
        end
      end
      pmv_pkg::TAB_DATA: begin
        tab_d = pmv_pkg::TAB_IDLE;
        thb_d = {1'b0, mem_rdata[14:8]};
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 5'h00;
      ctrl_q <= pmv_pkg::CTRL_RESET;
      tblp_q <= pmv_pkg::TBLP_RESET;
      thb_q <= pmv_pkg::THB_RESET;
      pc_q <= pmv_pkg::VEC_RESET;
      sp_q <= '0;
      tab_q <= pmv_pkg::TAB_IDLE;
      tab_addr_q <= 11'h000;
      tab_dest_q <= 7'h00;
      prog_addr_q <= 11'h000;
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= pmv_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= pmv_pkg::RESP_OKAY;
    end else begin
      flags_q <= flags_d;
      ctrl_q <= ctrl_d;
      tblp_q <= tblp_d;
      thb_q <= thb_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      tab_q <= tab_d;
      tab_addr_q <= tab_addr_d;
      tab_dest_q <= tab_dest_d;
      prog_addr_q <= prog_addr_d;
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // stack contents need no reset; the pointer guards them
  always_ff @(posedge aclk) begin
    stack_q <= stack_d;
  end

  // table lookup steals the read port for one cycle
  assign raddr = tab_start ? {core_req.tab_last ? pmv_pkg::LAST_PAGE
    : pc_q[10:8], tblp_q} : pc_d;

  pmv_code_store #(
    .DEPTH(pmv_pkg::MEM_DEPTH),
    .WIDTH(pmv_pkg::WORD_W),
    .AW(pmv_pkg::PC_W)
  ) u_store (
    .aclk(aclk),
    .we(mem_we),
    .waddr(prog_addr_q),
    .wdata(w_data_q[14:0]),
    .raddr(raddr),
    .rdata(mem_rdata)
  );

  assign axi_rsp.awready = ~aw_held_q & ~bvalid_q;
  assign axi_rsp.wready = ~w_held_q & ~bvalid_q;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.arready = ~rvalid_q;
  assign axi_rsp.rvalid = rvalid_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;
  assign pc = pc_q;
  assign fetch_word = mem_rdata;
  assign busy = core_busy;
  assign int_ack = ack;
  assign tab_wr_en = core_busy;
  assign tab_wr_addr = tab_dest_q;
  assign tab_wr_data = mem_rdata[7:0];

  property p_reset_pc;
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> pc_q == pmv_pkg::VEC_RESET;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not at reset vector");

  property p_ext_vec;
    @(posedge aclk) disable iff (!aresetn)
    (ack && ack_hot[pmv_pkg::SRC_EXT]) |=> pc_q == pmv_pkg::VEC_EXT;
  endproperty
  a_ext_vec: assert property (p_ext_vec) else $error("external vector missed");

  property p_fall_edge;
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_q[pmv_pkg::CTL_EDGE_LSB +: 2] == pmv_pkg::EDGE_FALL
      && ext_prev_q && !ext_sync_q)
      |=> flags_q[pmv_pkg::SRC_EXT];
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("falling edge lost");

  property p_full_blocks;
    @(posedge aclk) disable iff (!aresetn)
    stack_full |-> !int_ack;
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("ack on full stack");

  property p_push;
    @(posedge aclk) disable iff (!aresetn)
    (ack && !stack_full) |=> stack_q[sp_q - SP_W'(1)] == $past(pc_q);
  endproperty
  a_push: assert property (p_push) else $error("pc not pushed");

  property p_tab_addr;
    @(posedge aclk) disable iff (!aresetn)
    tab_start |=> tab_addr_q[7:0] == $past(tblp_q) && tab_addr_q[10:8] ==
      ($past(core_req.tab_last) ? pmv_pkg::LAST_PAGE : $past(pc_q[10:8]));
  endproperty
  a_tab_addr: assert property (p_tab_addr) else $error("bad table address");

  property p_two_cycles;
    @(posedge aclk) disable iff (!aresetn)
    tab_start |=> tab_wr_en ##1 !tab_wr_en;
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("table read length");

  property p_thb_only_table;
    @(posedge aclk) disable iff (!aresetn)
    $changed(thb_q) |-> $past(tab_wr_en) && thb_q[7] == 1'b0;
  endproperty
  a_thb_only_table: assert property (p_thb_only_table) else $error("high reg bad");

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
    (events[pmv_pkg::SRC_TB] && clr_mask[pmv_pkg::SRC_TB])
      |=> flags_q[pmv_pkg::SRC_TB];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");
endmodule // pmv_core
`default_nettype wire

// ===== pkg/pmv_pkg.sv
`default_nettype none
package pmv_pkg;
  // code store shape
  localparam int PC_W = 11;
  localparam int WORD_W = 15;
  localparam int MEM_DEPTH = 2048;
  localparam int STACK_DEPTH = 6;
  localparam int DEST_W = 7;
  // fixed entry locations in the code store
  localparam logic [10:0] VEC_RESET = 11'h000;
  localparam logic [10:0] VEC_EXT = 11'h004;
  localparam logic [10:0] VEC_TMR0 = 11'h008;
  localparam logic [10:0] VEC_TMR1 = 11'h00C;
  localparam logic [10:0] VEC_ADC = 11'h010;
  localparam logic [10:0] VEC_TB = 11'h014;
  localparam logic [2:0] LAST_PAGE = 3'h7;
  // interrupt source index, lowest index wins
  localparam int N_SRC = 5;
  localparam int SRC_EXT = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_TMR1 = 2;
  localparam int SRC_ADC = 3;
  localparam int SRC_TB = 4;
  // register byte offsets
  localparam logic [7:0] OFF_TBLP = 8'h00;
  localparam logic [7:0] OFF_THB = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_PROG_ADDR = 8'h14;
  localparam logic [7:0] OFF_PROG_DATA = 8'h18;
  // control register fields
  localparam int CTL_GIE = 0;
  localparam int CTL_EN_LSB = 1;
  localparam int CTL_EDGE_LSB = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] TBLP_RESET = 8'h00;
  localparam logic [7:0] THB_RESET = 8'h00;
  // status register fields
  localparam int ST_SP_LSB = 8;
  localparam int ST_FULL_BIT = 12;
  // edge select encodings
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TAB_IDLE = 2'b01,
    TAB_DATA = 2'b10
  } pmv_tab_state_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } pmv_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pmv_axi_rsp_t;

  typedef struct packed {
    logic step;
    logic jump;
    logic call;
    logic ret;
    logic reti;
    logic tab_cur;
    logic tab_last;
    logic [10:0] jump_addr;
    logic [6:0] tab_dest;
  } pmv_core_req_t;
endpackage
`default_nettype wire

// ===== core/pmv_code_store.sv
`timescale 1ns/1ps
`default_nettype none
module pmv_code_store #(
  parameter int DEPTH = pmv_pkg::MEM_DEPTH,
  parameter int WIDTH = pmv_pkg::WORD_W,
  parameter int AW = pmv_pkg::PC_W
) (
  input wire logic aclk, // system clock
  input wire logic we, // programming write strobe
  input wire logic [AW-1:0] waddr, // programming address
  input wire logic [WIDTH-1:0] wdata, // programming word
  input wire logic [AW-1:0] raddr, // read address
  output var logic [WIDTH-1:0] rdata // word read, one cycle later
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

  assign rdata = rdata_q;
endmodule // pmv_code_store
`default_nettype wire

// ===== test/pmv_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmv_core_model (
  input wire logic aclk, // system clock
  output var pmv_pkg::pmv_core_req_t core_req // requests into the block
);
  initial core_req = '0;
  // one request for one cycle, then one idle cycle, so a table read
  // is never chased by a request that busy would swallow
  task automatic issue(input pmv_pkg::pmv_core_req_t r);
    // table reads carry no step: no interrupt can land across one
    core_req <= r;
    @(posedge aclk);
    core_req <= '0;
    @(posedge aclk);
  endtask
endmodule // pmv_core_model
`default_nettype wire

// ===== test/pmv_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("mismatch t=%0t got %h want %h", $time, got, exp); \
    end \
  end
module pmv_core_tb_top;
  localparam logic [6:0] STEP = 7'h40;
  localparam logic [6:0] JMP = 7'h20;
  localparam logic [6:0] CALL = 7'h10;
  localparam logic [6:0] RET = 7'h08;
  localparam logic [6:0] RETI = 7'h0c;
  localparam logic [6:0] CUR = 7'h02;
  localparam logic [6:0] LAST = 7'h01;
  logic aclk;
  logic aresetn;
  pmv_pkg::pmv_axi_req_t req;
  pmv_pkg::pmv_axi_rsp_t rsp;
  pmv_pkg::pmv_core_req_t creq;
  logic pin;
  logic [4:0] ev;
  logic [10:0] pc;
  logic [14:0] fetch_word;
  logic busy;
  logic int_ack;
  logic tab_wr_en;
  logic [6:0] tab_wr_addr;
  logic [7:0] tab_wr_data;
  int err_count = 0;
  int checks_done = 0;
  int seed = 32'h00c8;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic [10:0] p0;
  // page 1 entry sits between last-page ones so the forced page is seen
  logic [10:0] ta [5] = '{11'h706, 11'h106, 11'h705, 11'h0ff, 11'h7ff};
  logic [14:0] tw [5];
  logic [10:0] vecs [5] = '{pmv_pkg::VEC_EXT, pmv_pkg::VEC_TMR0,
    pmv_pkg::VEC_TMR1, pmv_pkg::VEC_ADC, pmv_pkg::VEC_TB};

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  pmv_core i_pmv_core (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .core_req(creq), .ext_int_pin(pin), .tmr0_ovf(ev[1]),
    .tmr1_ovf(ev[2]), .adc_done(ev[3]), .tb_ovf(ev[4]), .pc(pc),
    .fetch_word(fetch_word), .busy(busy), .int_ack(int_ack),
    .tab_wr_en(tab_wr_en), .tab_wr_addr(tab_wr_addr),
    .tab_wr_data(tab_wr_data)
  );
  pmv_core_model i_pmv_core_model (.aclk(aclk), .core_req(creq));

  function automatic logic [7:0] thb(input logic [14:0] w);
    return {1'b0, w[14:8]};
  endfunction

  task automatic op(input logic [6:0] f, input logic [10:0] a,
                    input logic [6:0] d);
    i_pmv_core_model.issue({f, a, d});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && rsp.awready) req.awvalid <= 1'b0;
      if (w && rsp.wready) req.wvalid <= 1'b0;
      aw = aw && !rsp.awready;
      w = w && !rsp.wready;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    `CHK(rsp.bresp, er)
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    rdat = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    axr(a);
    `CHK(rdat, ed)
    `CHK(resp, er)
  endtask

  task automatic tab(input int i);
    logic [6:0] dst;
    logic lst;
    dst = 7'($random(seed));
    lst = (ta[i][10:8] == pmv_pkg::LAST_PAGE);
    if (!lst) op(JMP, {ta[i][10:8], 8'h00}, 7'h00);
    wr(pmv_pkg::OFF_TBLP, {24'h0000_00, ta[i][7:0]}, pmv_pkg::RESP_OKAY);
    fork
      op(lst ? LAST : CUR, 11'h000, dst);
      begin
        @(posedge aclk);
        #1;
        `CHK({busy, tab_wr_en}, 2'b11)
        `CHK(tab_wr_addr, dst)
        `CHK(tab_wr_data, tw[i][7:0])
        @(posedge aclk);
        #1;
        `CHK(busy, 1'b0)
        @(posedge aclk);
      end
    join
    rd(pmv_pkg::OFF_THB, {24'h0000_00, thb(tw[i])}, 2'h0);
  endtask

  task automatic irq(input int s, input logic [1:0] e, input logic en);
    logic hit;
    op(JMP, 11'($random(seed)), 7'h00);
    wr(pmv_pkg::OFF_CTRL, {24'h0000_00, e, 5'({4'h0, en} << s), 1'b1},
       pmv_pkg::RESP_OKAY);
    hit = en && (s != 0 || e == pmv_pkg::EDGE_BOTH ||
      (e == pmv_pkg::EDGE_RISE && !pin) || (e == pmv_pkg::EDGE_FALL && pin));
    if (s == 0) pin <= !pin;
    else ev[s] <= 1'b1;
    @(posedge aclk);
    ev <= 5'h00;
    repeat (4) @(posedge aclk);
    p0 = pc;
    fork
      op(STEP, 11'h000, 7'h00);
      begin
        #1;
        `CHK(int_ack, hit)
      end
    join
    `CHK(pc, hit ? vecs[s] : p0 + 11'h001)
    if (hit) begin
      op(RETI, 11'h000, 7'h00);
      `CHK(pc, p0)
    end
    wr(pmv_pkg::OFF_STATUS, 32'h0000_001f, pmv_pkg::RESP_OKAY);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    test_done();
  end

  initial begin
    aresetn = 1'b0;
    req = '0;
    pin = 1'b0;
    ev = 5'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    `CHK(pc, pmv_pkg::VEC_RESET)
    @(posedge aclk);
    rd(pmv_pkg::OFF_THB, 32'h0000_0000, pmv_pkg::RESP_OKAY);
    rd(pmv_pkg::OFF_CTRL, 32'h0000_0000, pmv_pkg::RESP_OKAY);
    rd(8'h1c, 32'h0000_0000, pmv_pkg::RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      tw[i] = 15'($random(seed));
      wr(pmv_pkg::OFF_PROG_ADDR, {21'h00_0000, ta[i]}, pmv_pkg::RESP_OKAY);
      wr(pmv_pkg::OFF_PROG_DATA, {17'h0_0000, tw[i]}, pmv_pkg::RESP_OKAY);
    end
    op(JMP, ta[0], 7'h00);
    @(posedge aclk);
    #1;
    `CHK(fetch_word, tw[0])
    @(posedge aclk);
    for (int i = 0; i < 5; i++) tab(i);
    wr(pmv_pkg::OFF_THB, 32'($random(seed)), pmv_pkg::RESP_SLVERR);
    rd(pmv_pkg::OFF_THB, {24'h0000_00, thb(tw[4])}, 2'h0);
    rd(pmv_pkg::OFF_TBLP, {24'h0000_00, ta[4][7:0]}, 2'h0);
    $display("test table done");
    for (int s = 1; s < 5; s++) begin
      irq(s, pmv_pkg::EDGE_OFF, 1'b0);
      irq(s, pmv_pkg::EDGE_OFF, 1'b1);
    end
    irq(0, pmv_pkg::EDGE_BOTH, 1'b0);
    for (int e = 0; e < 4; e++) begin
      irq(0, 2'(e), 1'b1);
      irq(0, 2'(e), 1'b1);
    end
    // time base event lands in the very cycle its flag is cleared
    fork
      wr(pmv_pkg::OFF_STATUS, 32'h0000_0010, pmv_pkg::RESP_OKAY);
      begin
        @(posedge aclk);
        ev[4] <= 1'b1;
        @(posedge aclk);
        ev <= 5'h00;
      end
    join
    axr(pmv_pkg::OFF_STATUS);
    `CHK(rdat[4], 1'b1)
    $display("test vectors done");
    for (int k = 0; k < 6; k++) op(CALL, 11'($random(seed)), 7'h00);
    axr(pmv_pkg::OFF_STATUS);
    `CHK(rdat[12], 1'b1)
    wr(pmv_pkg::OFF_CTRL, 32'h0000_0005, pmv_pkg::RESP_OKAY);
    ev[1] <= 1'b1;
    @(posedge aclk);
    ev <= 5'h00;
    repeat (3) @(posedge aclk);
    p0 = pc;
    op(STEP, 11'h000, 7'h00);
    `CHK(pc, p0 + 11'h001)
    axr(pmv_pkg::OFF_STATUS);
    `CHK(rdat[1], 1'b1)
    op(RET, 11'h000, 7'h00);
    op(STEP, 11'h000, 7'h00);
    `CHK(pc, pmv_pkg::VEC_TMR0)
    $display("test stack done");
    test_done();
  end
endmodule // pmv_core_tb_top
`default_nettype wire
